// ---- hdl/bdtc_mem.v ----
// Word memory with registered read data for the bus slave
`default_nettype none
module bdtc_mem #(
    parameter AW = 8,
    parameter DW = 16
) (
    input wire clk,
    input wire we,
    input wire [1:0] be,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata
);
    // Storage array
    reg [DW-1:0] mem [0:(1<<AW)-1];
    // Byte-lane write, registered read
    always @(posedge clk)
    begin
        if (we && be[0])
            mem[addr][7:0] <= wdata[7:0];
        if (we && be[1])
            mem[addr][15:8] <= wdata[15:8];
        rdata <= mem[addr];
    end
endmodule // bdtc_mem
`default_nettype wire

// ---- hdl/bdtc_slave.v ----
// Backplane data transfer slave: address latch, read, write, rmw, block
`default_nettype none
`include "bdtc_defines.vh"
module bdtc_slave #(
    parameter IO_SLAVE = 1,
    parameter MEM_IN_IO = 0,
    parameter [21:0] MEM_BASE = 22'h000000,
    parameter MEM_AW = `BDTC_MEM_DEPTH_LOG2
) (
    input wire clk,
    input wire srst,
    input wire [21:0] mux_addr_data_lines_n_in,
    output reg [21:0] mux_addr_data_lines_n_out,
    output reg mux_addr_data_lines_oe_n,
    input wire cycle_sync_strobe_n,
    input wire data_in_strobe_n,
    input wire data_out_strobe_n,
    input wire write_byte_control_n,
    input wire io_page_select_n,
    output reg slave_reply_strobe_n,
    output reg slave_selected,
    output reg parity_error_flag
);
    // Timing counts derived from ns figures at the clock rate
    localparam REPLY_MAX_CYC = (`BDTC_REPLY_MAX_NS / `BDTC_CLK_NS) < 1 ? 1 :
        (`BDTC_REPLY_MAX_NS / `BDTC_CLK_NS);
    localparam LEAD_CYC = (`BDTC_DATA_LEAD_NS / `BDTC_CLK_NS) < 1 ? 1 :
        (`BDTC_DATA_LEAD_NS / `BDTC_CLK_NS);
    // Sequencer states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SEL = 3'h1;
    localparam [2:0] ST_RD = 3'h2;
    localparam [2:0] ST_RDHOLD = 3'h3;
    localparam [2:0] ST_WR = 3'h4;
    localparam [2:0] ST_WRHOLD = 3'h5;
    localparam [2:0] ST_NOSEL = 3'h6;

    // Two-flop synchronisers on all pin inputs
    reg [21:0] dal_s1;
    reg [21:0] dal_s2;
    reg [4:0] ctl_s1;
    reg [4:0] ctl_s2;
    always @(posedge clk)
    begin
        dal_s1 <= ~mux_addr_data_lines_n_in;
        dal_s2 <= dal_s1;
        ctl_s1 <= ~{cycle_sync_strobe_n, data_in_strobe_n, data_out_strobe_n,
                    write_byte_control_n, io_page_select_n};
        ctl_s2 <= ctl_s1;
    end
    // Asserted-high views of the strobes
    wire sync = ctl_s2[4];
    wire din = ctl_s2[3];
    wire dout = ctl_s2[2];
    wire wtbt = ctl_s2[1];
    wire bs7 = ctl_s2[0];

    // Address match; an I/O slave ignores bits 21..13
    function hit;
        input [21:0] a;
        input io;
        begin
            if (IO_SLAVE != 0)
                hit = io && (a[12:MEM_AW+1] == `BDTC_IO_BASE >> (MEM_AW + 1));
            else
                hit = (!io || (MEM_IN_IO != 0)) &&
                    (a[21:MEM_AW+1] == MEM_BASE[21:MEM_AW+1]);
        end
    endfunction

    // Latched cycle context
    reg [2:0] state;
    reg [MEM_AW-1:0] word_addr;
    reg write_class;
    reg byte_hi;
    // Last transfer under this sync was a read, so a write now is rmw
    reg rd_last;
    reg [3:0] lead_cnt;
    reg mem_we;
    reg [1:0] mem_be;
    reg [15:0] mem_wdata;
    wire [15:0] mem_rdata;

    // Storage behind the slave
    bdtc_mem #(
        .AW(MEM_AW),
        .DW(`BDTC_DATA_W)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .be(mem_be),
        .addr(word_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // Main handshake sequencer
    always @(posedge clk)
    begin
        if (srst)
        begin
            state <= ST_IDLE;
            word_addr <= {MEM_AW{1'b0}};
            write_class <= 1'b0;
            byte_hi <= 1'b0;
            rd_last <= 1'b0;
            lead_cnt <= 4'h0;
            mem_we <= 1'b0;
            mem_be <= 2'h0;
            mem_wdata <= 16'h0000;
            mux_addr_data_lines_n_out <= 22'h3fffff;
            mux_addr_data_lines_oe_n <= 1'b1;
            slave_reply_strobe_n <= 1'b1;
            slave_selected <= 1'b0;
            parity_error_flag <= 1'b0;
        end
        else
        begin
            mem_we <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    // Capture address on sync assertion
                    if (sync)
                    begin
                        if (hit(dal_s2, bs7))
                        begin
                            word_addr <= dal_s2[MEM_AW:1];
                            write_class <= wtbt;
                            byte_hi <= dal_s2[`BDTC_BYTE_SEL_BIT];
                            rd_last <= 1'b0;
                            slave_selected <= 1'b1;
                            state <= ST_SEL;
                        end
                        else
                            state <= ST_NOSEL;
                    end
                end
                ST_SEL:
                begin
                    // Selection stands while sync is held
                    if (!sync)
                    begin
                        slave_selected <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else if (din)
                    begin
                        // Reply at once; data follows from the memory register
                        slave_reply_strobe_n <= 1'b0;
                        lead_cnt <= 4'h0;
                        state <= ST_RD;
                    end
                    else if (dout)
                    begin
                        // Write after write address or rmw input
                        mem_we <= 1'b1;
                        mem_wdata <= dal_s2[15:0];
                        parity_error_flag <= dal_s2[`BDTC_PAR_ERR_BIT];
                        // Rmw output goes back to the word just read
                        if (rd_last)
                            word_addr <= word_addr - 1'b1;
                        rd_last <= 1'b0;
                        // Byte lane follows write/byte control in the data phase
                        if (wtbt)
                            mem_be <= byte_hi ? 2'h2 : 2'h1;
                        else
                            mem_be <= 2'h3;
                        slave_reply_strobe_n <= 1'b0;
                        state <= ST_WR;
                    end
                end
                ST_RD:
                begin
                    // Drive data after data-in, within lead of reply
                    mux_addr_data_lines_oe_n <= 1'b0;
                    mux_addr_data_lines_n_out <= ~{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                        1'b0, mem_rdata};
                    if (lead_cnt < LEAD_CYC[3:0])
                        lead_cnt <= lead_cnt + 4'h1;
                    state <= ST_RDHOLD;
                end
                ST_RDHOLD:
                begin
                    // Reply drops first; data released a cycle later
                    if (!din)
                    begin
                        slave_reply_strobe_n <= 1'b1;
                        rd_last <= 1'b1;
                        // Next word of a block follows on the next strobe
                        word_addr <= word_addr + 1'b1;
                        state <= ST_SEL;
                    end
                    if (slave_reply_strobe_n)
                        mux_addr_data_lines_oe_n <= 1'b1;
                end
                ST_WR:
                begin
                    // Hold reply until data-out drops
                    if (!dout)
                    begin
                        slave_reply_strobe_n <= 1'b1;
                        word_addr <= word_addr + 1'b1;
                        state <= ST_SEL;
                    end
                end
                ST_NOSEL:
                begin
                    // Unselected: wait out the cycle
                    mux_addr_data_lines_oe_n <= 1'b1;
                    if (!sync)
                    begin
                        slave_selected <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
            // Release read drivers once reply has been negated
            if (state == ST_SEL && !din)
                mux_addr_data_lines_oe_n <= 1'b1;
        end
    end
endmodule // bdtc_slave
`default_nettype wire

// ---- pkg/bdtc_defines.vh ----
// Constants for the backplane data transfer slave
`ifndef BDTC_DEFINES_VH
`define BDTC_DEFINES_VH
`define BDTC_CLK_NS 40
`define BDTC_ADDR_W 22
`define BDTC_IO_LOW_BITS 13
`define BDTC_DATA_W 16
`define BDTC_REPLY_MAX_NS 8
`define BDTC_DATA_LEAD_NS 125
`define BDTC_REL_GAP_NS 100
`define BDTC_PAR_ERR_BIT 16
`define BDTC_PAR_EN_BIT 17
`define BDTC_BYTE_SEL_BIT 0
`define BDTC_MEM_DEPTH_LOG2 8
`define BDTC_IO_BASE 13'h1f00
`endif

// ---- sim/bdtc_master.sv ----
// Bus master model driving the slave's strobes
`default_nettype none
module bdtc_master (
    input wire logic clk,
    input wire logic [21:0] bus_n,
    input wire logic reply_n,
    output logic [21:0] lines_n,
    output logic sync_n,
    output logic din_n,
    output logic dout_n,
    output logic wtbt_n,
    output logic bs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    int tmo = 0;
    initial {lines_n, sync_n, din_n, dout_n, wtbt_n, bs_n} = '1;
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask
    // Address held past sync, then released high
    task automatic start(input logic [21:0] a, input logic io, input logic wr);
        lines_n = ~a; bs_n = ~io; wtbt_n = ~wr;
        idle(2);
        sync_n = 0;
        idle(3);
        lines_n = '1;
    endtask
    // Bounded wait for reply to reach a level
    task automatic wait_rep(input logic lvl);
        for (n = 0; n < 50 && reply_n != lvl; n++) @(negedge clk);
        // A reply that never releases is a hang
        if (lvl && reply_n != lvl) tmo++;
    endtask
    task automatic rd(output logic [21:0] d, output logic ok);
        din_n = 0;
        wait_rep(0);
        ok = !reply_n;
        idle(5);
        d = ~bus_n;
        din_n = 1;
        wait_rep(1);
    endtask
    task automatic wr(input logic [15:0] d, input logic byt, output logic ok);
        lines_n = {6'h3f, ~d}; wtbt_n = ~byt;
        idle(5);
        dout_n = 0;
        wait_rep(0);
        ok = !reply_n;
        idle(4);
        dout_n = 1;
        wait_rep(1);
        idle(3);
        lines_n = '1;
    endtask
    // Sync drops after reply, spacing kept
    task automatic stop();
        sync_n = 1; wtbt_n = 1; bs_n = 1;
        idle(8);
    endtask
endmodule // bdtc_master
`default_nettype wire

// ---- sim/bdtc_props.sv ----
// Assertion checker for the bus slave ports
`default_nettype none
module bdtc_props (
    input wire clk,
    input wire srst,
    input wire mux_addr_data_lines_oe_n,
    input wire cycle_sync_strobe_n,
    input wire data_in_strobe_n,
    input wire data_out_strobe_n,
    input wire io_page_select_n,
    input wire slave_reply_strobe_n,
    input wire slave_selected
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Reply only from a selected slave
    chk_reply_when_sel: assert property (!slave_reply_strobe_n |-> slave_selected)
        else $error("reply without selection");
    chk_sel_drops: assert property (cycle_sync_strobe_n [*4] |-> !slave_selected)
        else $error("selection kept after sync");
    chk_io_needs_page: assert property ($rose(slave_selected) |-> !$past(io_page_select_n, 2))
        else $error("selected without page select");
    chk_reply_prompt: assert property ($fell(data_in_strobe_n) && slave_selected
        |-> ##[1:4] !slave_reply_strobe_n)
        else $error("reply late");
    chk_reply_held: assert property (!slave_reply_strobe_n
        && !(data_in_strobe_n && data_out_strobe_n) |=> !slave_reply_strobe_n)
        else $error("reply dropped early");
    chk_data_lead: assert property ($fell(slave_reply_strobe_n) && !data_in_strobe_n
        |-> ##[0:3] !mux_addr_data_lines_oe_n)
        else $error("read data late");
    chk_release_order: assert property ($rose(mux_addr_data_lines_oe_n) |-> slave_reply_strobe_n)
        else $error("data released before reply");
    chk_data_after_din: assert property ($fell(mux_addr_data_lines_oe_n)
        |-> !$past(data_in_strobe_n, 3))
        else $error("data driven before data-in");
endmodule // bdtc_props
bind bdtc_slave bdtc_props u_props (
    .clk(clk),
    .srst(srst),
    .mux_addr_data_lines_oe_n(mux_addr_data_lines_oe_n),
    .cycle_sync_strobe_n(cycle_sync_strobe_n),
    .data_in_strobe_n(data_in_strobe_n),
    .data_out_strobe_n(data_out_strobe_n),
    .io_page_select_n(io_page_select_n),
    .slave_reply_strobe_n(slave_reply_strobe_n),
    .slave_selected(slave_selected)
);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the bus slave
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [21:0] A = 22'h001f00;
    logic clk = 0, srst = 1, ok;
    logic [21:0] d, out, lines_n;
    logic oe_n, sync_n, din_n, dout_n, wtbt_n, bs_n, rep_n, sel, perr;
    int error_cnt = 0, num_checks = 0;
    // Wired-and of both drivers, pulled high
    wire [21:0] bus_n = lines_n & (oe_n ? 22'h3fffff : out);
    initial forever #20 clk = ~clk;
    bdtc_slave uut (.clk(clk), .srst(srst), .mux_addr_data_lines_n_in(bus_n),
        .mux_addr_data_lines_n_out(out), .mux_addr_data_lines_oe_n(oe_n),
        .cycle_sync_strobe_n(sync_n), .data_in_strobe_n(din_n), .data_out_strobe_n(dout_n),
        .write_byte_control_n(wtbt_n), .io_page_select_n(bs_n),
        .slave_reply_strobe_n(rep_n), .slave_selected(sel), .parity_error_flag(perr));
    bdtc_master m (.clk(clk), .bus_n(bus_n), .reply_n(rep_n), .lines_n(lines_n),
        .sync_n(sync_n), .din_n(din_n), .dout_n(dout_n), .wtbt_n(wtbt_n), .bs_n(bs_n));
    task automatic cmp(input logic [21:0] got, input logic [21:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd_at(input logic [21:0] a, input logic io, input logic [15:0] exp);
        m.start(a, io, 0);
        m.rd(d, ok);
        m.stop();
        cmp(ok, io);
        if (io) cmp(d[15:0], exp);
    endtask
    task automatic t_word_byte();
        m.start(A, 1, 1);
        m.wr(16'h5aa5, 0, ok); cmp(ok, 1);
        m.stop();
        m.start(A | 22'h1, 1, 1);
        m.wr(16'h3c00, 1, ok); cmp(ok, 1);
        m.stop();
        rd_at(A, 1, 16'h3ca5);
        cmp(perr, 0);
        $display("word and byte done");
    endtask
    task automatic t_decode();
        rd_at(A, 0, 0);
        rd_at(A | 22'h3fe000, 1, 16'h3ca5);
        $display("decode done");
    endtask
    task automatic t_block_rmw();
        m.start(A, 1, 1);
        m.wr(16'h1111, 0, ok); cmp(ok, 1);
        m.wr(16'h2222, 0, ok); cmp(ok, 1);
        m.stop();
        rd_at(A + 22'h2, 1, 16'h2222);
        m.start(A, 1, 0);
        m.rd(d, ok); cmp(d[15:0], 16'h1111);
        m.wr(16'h7777, 0, ok); cmp(ok, 1);
        m.stop();
        rd_at(A, 1, 16'h7777);
        rd_at(A + 22'h2, 1, 16'h2222);
        $display("block and rmw done");
    endtask
    task automatic print_verdict();
        error_cnt += m.tmo;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        srst = 0;
        t_word_byte();
        t_decode();
        t_block_rmw();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
